// ---- rtl/lbs_pkg.sv ----
// constants and types of the led behaviour sequencer
package lbs_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_LINK      = 8'h72;
  localparam logic [7:0] ADDR_POLARITY  = 8'h73;
  localparam logic [7:0] ADDR_DRIVE     = 8'h74;
  localparam logic [7:0] ADDR_MODE_LOW  = 8'h81;
  localparam logic [7:0] ADDR_MODE_HIGH = 8'h82;
  localparam logic [7:0] ADDR_PULSE_A   = 8'h84;
  localparam logic [7:0] ADDR_PULSE_B   = 8'h85;
  localparam logic [7:0] ADDR_BREATHE   = 8'h86;
  localparam logic [7:0] ADDR_CONFIG    = 8'h88;
  localparam logic [7:0] ADDR_STATUS    = 8'h8f;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_PULSE_A  = 8'h20;
  localparam logic [6:0] RST_PULSE_B  = 7'h14;
  localparam logic [6:0] RST_BREATHE  = 7'h5d;
  localparam logic [6:0] RST_CONFIG   = 7'h04;
  localparam int         START_REL_BIT = 7;
  localparam int         CNT_A_LSB     = 0;
  localparam int         CNT_B_LSB     = 3;
  localparam int         NUM_CHAN      = 6;

  // ****************************************************************
  // timing: one period lsb is 32 ms, ramped in 1 ms steps
  // ****************************************************************
  localparam int         CLK_MHZ        = 50;
  localparam int         PERIOD_LSB_MS  = 32;
  localparam int         STEP_US        = 1000;
  localparam int         STEP_CYC       = STEP_US * CLK_MHZ;
  localparam logic [6:0] MIN_PERIOD     = 7'h05;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_DIRECT, MODE_PULSE_A, MODE_PULSE_B, MODE_BREATHE
  } lbs_mode_type;

  typedef enum logic [1:0] {
    PH_IDLE, PH_DIRECT, PH_BREATHE, PH_PULSE
  } lbs_phase_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } lbs_bus_req_type;

  typedef struct packed {
    lbs_phase_type phase;
    lbs_mode_type  mode;
    logic [2:0]    pulsesDone;
    logic [10:0]   pos;
    logic          down;
    logic [10:0]   pwm;
    logic          prevTrig;
  } lbs_chan_type;

endpackage

// ---- rtl/lbs_sequencer.sv ----
// led behaviour sequencer: six channels, registers and pin drive
// Operation
// R1: each channel has a 2-bit behaviour field across two mode registers
// R2: linked channel starts and stops on its mode's touch triggers
// R3: unlinked channel treats drive bit one as touch, zero as release
// R4: not actuated pin sits at one when inverted, zero when not
// R5: unlinked breathing channel finishes its breath before any change
// R6: unlinked pulse A starts on drive bit and ignores it until done
// R7: link change makes the channel follow the new source at once
// R8: period write restarts ramps from zero, pulse counts are kept
// R9: direct mode drives active on touch, inactive on release
// R10: pulse A gives programmed pulses, min to max to min each
// R11: pulse B breathes until stop, then pulses and rests at minimum
// R12: breathe ramps up and down, each ramp half the period
// R13: period fields count 32 ms steps, zero and one both 32 ms; here values below 5 both run as 160 ms
// R14: pulse A, pulse B and breathe periods come from own registers
// R15: pulse A period bit 7 picks touch or release start when linked
// R16: periods below 160 ms run at the shortest achievable period
// R17: pwm rate follows mode and period, direct runs fastest
// R18: 3-bit pulse count fields give one to eight pulses
// R19: link bit makes sensor touch and release the channel triggers
// R20: breathing ramps from minimum up first, then back down
// R21: one shared prescaler times all channels
// R22: reset idles channels, clears counts and loads register defaults
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module lbs_sequencer #(
  parameter int STEP_CYC = lbs_pkg::STEP_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire lbs_pkg::lbs_bus_req_type busReq,
  output logic [7:0]                    rdData,
  input  wire logic [5:0]               touchDetect,
  output logic [5:0]                    ledPin
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [5:0]                 link;
    logic [5:0]                 polarity;
    logic [5:0]                 drive;
    logic [7:0]                 modeLow;
    logic [3:0]                 modeHigh;
    logic [7:0]                 pulseAPer;
    logic [6:0]                 pulseBPer;
    logic [6:0]                 breathPer;
    logic [6:0]                 ledCfg;
    logic [15:0]                prescale;
    logic                       stepTick;
    lbs_pkg::lbs_chan_type [5:0] chan;
    logic [7:0]                 rdData;
    logic [5:0]                 ledPin;
  } lbs_state_type;

  lbs_state_type st_r;
  lbs_state_type st_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // ramp length of one half breath in 1 ms steps, short periods clamped
  function automatic logic [10:0] halfLen(input logic [6:0] per);
    logic [6:0] eff;
    eff = (per < lbs_pkg::MIN_PERIOD) ? lbs_pkg::MIN_PERIOD : per; // R16
    halfLen = {eff, 4'h0}; // R13
  endfunction

  // period in use for a channel, by its latched behaviour
  function automatic logic [10:0] chanHalf(
    input lbs_pkg::lbs_mode_type m,
    input logic [7:0]            perA,
    input logic [6:0]            perB,
    input logic [6:0]            perBr
  );
    case (m)
      lbs_pkg::MODE_PULSE_A: chanHalf = halfLen(perA[6:0]); // R14
      lbs_pkg::MODE_PULSE_B: chanHalf = halfLen(perB);      // R14
      default:               chanHalf = halfLen(perBr);     // R14
    endcase
  endfunction

  // behaviour field of one channel
  function automatic lbs_pkg::lbs_mode_type modeOf(
    input logic [7:0] lo,
    input logic [3:0] hi,
    input int         idx
  );
    logic [11:0] all;
    all = {hi, lo};
    modeOf = lbs_pkg::lbs_mode_type'(all[2*idx +: 2]); // R1
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    lbs_pkg::lbs_chan_type    c;
    lbs_pkg::lbs_mode_type    sel;
    logic [10:0]              half;
    logic [10:0]              bright;
    logic [2:0]               target;
    logic                     trig;
    logic                     rise;
    logic                     fall;
    logic                     linked;
    logic                     breathing;
    logic                     endBreath;
    logic                     perWrite;
    logic                     on;
    logic                     act;
    logic [5:0]               actuated;
    c         = '0;
    sel       = lbs_pkg::MODE_DIRECT;
    half      = '0;
    bright    = '0;
    target    = '0;
    trig      = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    linked    = 1'b0;
    breathing = 1'b0;
    endBreath = 1'b0;
    perWrite  = 1'b0;
    on        = 1'b0;
    act       = 1'b0;
    actuated  = '0;
    st_nxt    = st_r;

    // shared step prescaler keeps channels in step
    st_nxt.stepTick = 1'b0;
    if (st_r.prescale >= 16'(STEP_CYC - 1)) begin // R21
      st_nxt.prescale = '0;
      st_nxt.stepTick = 1'b1;
    end else begin
      st_nxt.prescale = st_r.prescale + 16'h0001;
    end

    // register writes
    perWrite = busReq.wrStb &&
               (busReq.addr == lbs_pkg::ADDR_PULSE_A ||
                busReq.addr == lbs_pkg::ADDR_PULSE_B ||
                busReq.addr == lbs_pkg::ADDR_BREATHE);
    if (busReq.wrStb) begin
      case (busReq.addr)
        lbs_pkg::ADDR_LINK:      st_nxt.link      = busReq.wrData[5:0];
        lbs_pkg::ADDR_POLARITY:  st_nxt.polarity  = busReq.wrData[5:0];
        lbs_pkg::ADDR_DRIVE:     st_nxt.drive     = busReq.wrData[5:0];
        lbs_pkg::ADDR_MODE_LOW:  st_nxt.modeLow   = busReq.wrData; // R1
        lbs_pkg::ADDR_MODE_HIGH: st_nxt.modeHigh  = busReq.wrData[3:0];
        lbs_pkg::ADDR_PULSE_A:   st_nxt.pulseAPer = busReq.wrData;
        lbs_pkg::ADDR_PULSE_B:   st_nxt.pulseBPer = busReq.wrData[6:0];
        lbs_pkg::ADDR_BREATHE:   st_nxt.breathPer = busReq.wrData[6:0];
        lbs_pkg::ADDR_CONFIG:    st_nxt.ledCfg    = busReq.wrData[6:0];
        default: ;
      endcase
    end

    // per-channel sequencing
    for (int i = 0; i < lbs_pkg::NUM_CHAN; i++) begin
      c      = st_r.chan[i];
      sel    = modeOf(st_r.modeLow, st_r.modeHigh, i);
      linked = st_r.link[i]; // R19
      // source follows the link bit at once, so a switch acts now
      trig   = linked ? touchDetect[i] : st_r.drive[i]; // R3 R7
      rise   = trig & ~c.prevTrig;
      fall   = ~trig & c.prevTrig;
      c.prevTrig = trig;
      half   = chanHalf(c.mode, st_r.pulseAPer, st_r.pulseBPer,
                        st_r.breathPer);
      breathing = (c.phase == lbs_pkg::PH_BREATHE) ||
                  (c.phase == lbs_pkg::PH_PULSE);

      // pwm frame is half clock cycles long so duty is pos over half
      if (c.phase == lbs_pkg::PH_DIRECT || c.pwm >= half - 11'h001) begin
        c.pwm = '0; // R17
      end else begin
        c.pwm = c.pwm + 11'h001;
      end

      // ramp up first, then down; a breath ends at the bottom
      endBreath = 1'b0;
      if (breathing && st_r.stepTick) begin
        if (c.pos >= half - 11'h001) begin
          c.pos = '0;
          endBreath = c.down;
          c.down = ~c.down; // R20 R12
        end else begin
          c.pos = c.pos + 11'h001;
        end
      end

      // pulse count target, code plus one pulses
      target = (c.mode == lbs_pkg::MODE_PULSE_A) ?
               st_r.ledCfg[lbs_pkg::CNT_A_LSB +: 3] :
               st_r.ledCfg[lbs_pkg::CNT_B_LSB +: 3]; // R18

      case (c.phase)
        lbs_pkg::PH_IDLE: begin
          c.pos  = '0;
          c.down = 1'b0;
          c.pulsesDone = '0;
          c.mode = sel;
          case (sel)
            lbs_pkg::MODE_DIRECT: begin
              if (trig) c.phase = lbs_pkg::PH_DIRECT; // R9
            end
            lbs_pkg::MODE_PULSE_A: begin
              if (linked ? (st_r.pulseAPer[lbs_pkg::START_REL_BIT] ?
                            fall : rise) : trig) begin
                c.phase = lbs_pkg::PH_PULSE; // R15 R6 R2
              end
            end
            default: begin
              if (trig) c.phase = lbs_pkg::PH_BREATHE; // R2 R11 R12
            end
          endcase
        end
        lbs_pkg::PH_DIRECT: begin
          if (!trig || sel != lbs_pkg::MODE_DIRECT) begin
            c.phase = lbs_pkg::PH_IDLE; // R9
          end
        end
        lbs_pkg::PH_BREATHE: begin
          // unlinked channels only act on a breath boundary
          if (linked || endBreath) begin // R5
            if (sel != c.mode) begin
              c.phase = lbs_pkg::PH_IDLE;
            end else if (!trig) begin
              if (c.mode == lbs_pkg::MODE_PULSE_B) begin
                c.phase = lbs_pkg::PH_PULSE; // R11
                c.pos   = '0;
                c.down  = 1'b0;
              end else begin
                c.phase = lbs_pkg::PH_IDLE; // R12
              end
            end
          end
        end
        lbs_pkg::PH_PULSE: begin
          // drive bit is not looked at here, no stop trigger
          if (endBreath) begin
            if (c.pulsesDone == target) begin
              c.phase = lbs_pkg::PH_IDLE; // R10 R11
            end else begin
              c.pulsesDone = c.pulsesDone + 3'h1;
            end
          end
          if (linked && sel != c.mode) begin
            c.phase = lbs_pkg::PH_IDLE;
          end else if (!linked && endBreath && sel != c.mode) begin
            c.phase = lbs_pkg::PH_IDLE; // R5
          end
        end
        default: c.phase = lbs_pkg::PH_IDLE;
      endcase

      // new period restarts the ramp at zero drive
      if (perWrite && breathing &&
          (c.phase == lbs_pkg::PH_BREATHE || c.phase == lbs_pkg::PH_PULSE))
      begin
        c.pos  = '0; // R8
        c.down = 1'b0;
        c.pwm  = '0;
      end

      // duty drive: brightness is the ramp position
      bright = c.down ? (half - c.pos) : c.pos;
      act    = (c.phase != lbs_pkg::PH_IDLE);
      case (c.phase)
        lbs_pkg::PH_DIRECT:  on = 1'b1; // R9
        lbs_pkg::PH_BREATHE: on = c.pwm < bright;
        lbs_pkg::PH_PULSE:   on = c.pwm < bright;
        default:             on = 1'b0;
      endcase
      actuated[i] = act;
      // polarity bit zero is inverted: active drives low
      st_nxt.ledPin[i] = st_r.polarity[i] ? on : ~on; // R4
      st_nxt.chan[i]   = c;
    end

    // register reads, data valid the cycle after the strobe
    st_nxt.rdData = '0;
    if (busReq.rdStb) begin
      case (busReq.addr)
        lbs_pkg::ADDR_LINK:      st_nxt.rdData = {2'h0, st_r.link};
        lbs_pkg::ADDR_POLARITY:  st_nxt.rdData = {2'h0, st_r.polarity};
        lbs_pkg::ADDR_DRIVE:     st_nxt.rdData = {2'h0, st_r.drive};
        lbs_pkg::ADDR_MODE_LOW:  st_nxt.rdData = st_r.modeLow;
        lbs_pkg::ADDR_MODE_HIGH: st_nxt.rdData = {4'h0, st_r.modeHigh};
        lbs_pkg::ADDR_PULSE_A:   st_nxt.rdData = st_r.pulseAPer;
        lbs_pkg::ADDR_PULSE_B:   st_nxt.rdData = {1'b0, st_r.pulseBPer};
        lbs_pkg::ADDR_BREATHE:   st_nxt.rdData = {1'b0, st_r.breathPer};
        lbs_pkg::ADDR_CONFIG:    st_nxt.rdData = {1'b0, st_r.ledCfg};
        lbs_pkg::ADDR_STATUS:    st_nxt.rdData = {2'h0, actuated};
        default:                 st_nxt.rdData = '0;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // synchronous reset loads defaults and idles every channel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r           <= '0; // R22
      st_r.pulseAPer <= lbs_pkg::RST_PULSE_A;
      st_r.pulseBPer <= lbs_pkg::RST_PULSE_B;
      st_r.breathPer <= lbs_pkg::RST_BREATHE;
      st_r.ledCfg    <= lbs_pkg::RST_CONFIG;
      st_r.ledPin    <= 6'h3f; // R4
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign ledPin = st_r.ledPin;

endmodule

// ---- verif/lbs_led_model.sv ----
// lamp model watching the first led pin of the sequencer
`timescale 1ns/1ps

module lbs_led_model (
  input  wire logic       sys_clk,
  input  wire logic [5:0] ledPin,
  input  wire logic [5:0] activeLvl,
  input  wire logic       clear,
  output logic [15:0]     onCnt,
  output logic [15:0]     span
);
  logic [15:0] nowCnt;
  logic [15:0] firstOn;
  logic        seen;

  // lamp one only: lit cycles and first-to-last lit span since clear
  always @(posedge sys_clk) begin
    if (clear) begin
      nowCnt <= 16'h0000;
      onCnt <= 16'h0000;
      span <= 16'h0000;
      firstOn <= 16'h0000;
      seen <= 1'b0;
    end else begin
      nowCnt <= nowCnt + 16'h0001;
      if (ledPin[0] == activeLvl[0]) begin
        onCnt <= onCnt + 16'h0001;
        if (!seen) begin
          firstOn <= nowCnt;
          seen <= 1'b1;
        end else begin
          span <= nowCnt - firstOn;
        end
      end
    end
  end
endmodule

// ---- verif/lbs_sequencer_checker.sv ----
// port assertions for the led behaviour sequencer
`timescale 1ns/1ps

module lbs_sequencer_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire lbs_pkg::lbs_bus_req_type busReq,
  input wire logic [7:0]               rdData,
  input wire logic [5:0]               touchDetect,
  input wire logic [5:0]               ledPin
);
  logic [7:0] modeR;
  logic [7:0] linkR;
  logic [7:0] polR;
  logic       dirLink;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // shadow of the registers steering channel one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeR <= 8'h00;
      linkR <= 8'h00;
      polR <= 8'h00;
    end else if (busReq.wrStb) begin
      if (busReq.addr == lbs_pkg::ADDR_MODE_LOW)
        modeR <= busReq.wrData;
      if (busReq.addr == lbs_pkg::ADDR_LINK)
        linkR <= busReq.wrData;
      if (busReq.addr == lbs_pkg::ADDR_POLARITY)
        polR <= busReq.wrData;
    end
  end

  // channel one in direct mode following its sensor
  assign dirLink = (modeR[1:0] == 2'b00) && linkR[0];

  sequence wr_mode_s;
    busReq.wrStb && busReq.addr == lbs_pkg::ADDR_MODE_LOW;
  endsequence

  sequence rd_mode_s;
    busReq.rdStb && busReq.addr == lbs_pkg::ADDR_MODE_LOW;
  endsequence

  reset_pins_a: assert property (
    $fell(rst) |-> ledPin == 6'h3f)
    else $error("pins not idle after reset");
  mode_roundtrip_a: assert property (
    wr_mode_s ##1 rd_mode_s |=> rdData == $past(busReq.wrData, 2))
    else $error("mode register readback wrong");
  mode_high_rsv_a: assert property (
    busReq.rdStb && busReq.addr == lbs_pkg::ADDR_MODE_HIGH
      |=> rdData[7:4] == 4'h0)
    else $error("upper mode bits not zero");
  pulse_b_rsv_a: assert property (
    busReq.rdStb && busReq.addr == lbs_pkg::ADDR_PULSE_B |=> !rdData[7])
    else $error("pulse b bit 7 not zero");
  breathe_rsv_a: assert property (
    busReq.rdStb && busReq.addr == lbs_pkg::ADDR_BREATHE |=> !rdData[7])
    else $error("breathe bit 7 not zero");
  rd_quiet_a: assert property (
    !$past(busReq.rdStb) && !$past(rst) |-> rdData == 8'h00)
    else $error("read data outside read slot");
  direct_touch_a: assert property (
    (dirLink && touchDetect[0] && $stable(polR))[*4]
      |-> ledPin[0] == polR[0])
    else $error("direct touch not active");
  direct_release_a: assert property (
    (dirLink && !touchDetect[0] && $stable(polR))[*4]
      |-> ledPin[0] == !polR[0])
    else $error("direct release not inactive");
endmodule

bind lbs_sequencer lbs_sequencer_checker lbs_sequencer_checker_inst (
  .sys_clk     (sys_clk),
  .rst         (rst),
  .busReq      (busReq),
  .rdData      (rdData),
  .touchDetect (touchDetect),
  .ledPin      (ledPin)
);

// ---- verif/lbs_sequencer_tb.sv ----
// self-checking bench for the led behaviour sequencer
`timescale 1ns/1ps

module lbs_sequencer_tb;
  localparam int STEP = 4;
  // one breath at the clamped shortest period: two ramps of 80 steps
  localparam int BREATH = 2 * 16 * 5 * STEP;
  logic                     sys_clk;
  logic                     rst;
  lbs_pkg::lbs_bus_req_type busReq;
  logic [7:0]               rdData;
  logic [5:0]               touchDetect;
  logic [5:0]               ledPin;
  logic [5:0]               activeLvl;
  logic                     modelClr;
  logic [15:0]              onCnt;
  logic [15:0]              span;
  int                       num_errors;
  int                       samples_checked;

  lbs_sequencer #(.STEP_CYC(STEP)) lbs_sequencer_inst (
    .sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .touchDetect(touchDetect), .ledPin(ledPin));
  lbs_led_model lbs_led_model_inst (
    .sys_clk(sys_clk), .ledPin(ledPin), .activeLvl(activeLvl),
    .clear(modelClr), .onCnt(onCnt), .span(span));

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask

  // optional write right before the read, back to back
  task automatic bus_rd(input logic [7:0] a, input logic wr,
                        input logic [7:0] d, input logic [7:0] exp);
    if (wr) begin
      @(posedge sys_clk);
      busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    end
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    check({8'h00, rdData}, {8'h00, exp});
  endtask

  task automatic pins(input int n, input logic [5:0] exp);
    repeat (n) @(posedge sys_clk);
    #1;
    check({10'h000, ledPin}, {10'h000, exp});
  endtask

  task automatic touch(input logic [5:0] t);
    @(posedge sys_clk);
    touchDetect <= t;
  endtask

  task automatic clr();
    @(posedge sys_clk);
    modelClr <= 1'b1;
    @(posedge sys_clk);
    modelClr <= 1'b0;
  endtask

  task automatic t_regs();
    pins(1, 6'h3f);
    bus_rd(lbs_pkg::ADDR_MODE_LOW, 1'b0, 8'h00, 8'h00);
    bus_rd(lbs_pkg::ADDR_PULSE_A, 1'b0, 8'h00, 8'h20);
    bus_rd(lbs_pkg::ADDR_PULSE_B, 1'b0, 8'h00, 8'h14);
    bus_rd(lbs_pkg::ADDR_BREATHE, 1'b0, 8'h00, 8'h5d);
    bus_rd(8'h80, 1'b1, 8'h5a, 8'h00);
    bus_rd(lbs_pkg::ADDR_MODE_LOW, 1'b1, 8'hc6, 8'hc6);
    bus_rd(lbs_pkg::ADDR_MODE_HIGH, 1'b1, 8'hff, 8'h0f);
    bus_rd(lbs_pkg::ADDR_PULSE_A, 1'b1, 8'ha5, 8'ha5);
    bus_rd(lbs_pkg::ADDR_PULSE_B, 1'b1, 8'hff, 8'h7f);
    bus_rd(lbs_pkg::ADDR_BREATHE, 1'b1, 8'hff, 8'h7f);
  endtask

  // channel six breathes, the rest direct, all linked
  task automatic t_linked();
    bus_wr(lbs_pkg::ADDR_MODE_LOW, 8'h00);
    bus_wr(lbs_pkg::ADDR_MODE_HIGH, 8'h0c);
    bus_wr(lbs_pkg::ADDR_LINK, 8'h3f);
    touch(6'h3f);
    pins(6, 6'h20);
    touch(6'h00);
    pins(6, 6'h3f);
    bus_wr(lbs_pkg::ADDR_POLARITY, 8'h3f);
    pins(4, 6'h00);
    touch(6'h3f);
    pins(6, 6'h1f);
    touch(6'h00);
    bus_wr(lbs_pkg::ADDR_POLARITY, 8'h00);
    bus_wr(lbs_pkg::ADDR_MODE_HIGH, 8'h00);
  endtask

  // host drive bit as touch, then moving the source back and forth
  task automatic t_unlinked();
    bus_wr(lbs_pkg::ADDR_LINK, 8'h00);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h02);
    pins(6, 6'h3d);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h00);
    pins(6, 6'h3f);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h02);
    bus_wr(lbs_pkg::ADDR_LINK, 8'h02);
    pins(5, 6'h3f);
    bus_wr(lbs_pkg::ADDR_LINK, 8'h00);
    pins(5, 6'h3d);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h00);
  endtask

  task automatic t_breathe();
    bus_wr(lbs_pkg::ADDR_MODE_LOW, 8'h03);
    bus_wr(lbs_pkg::ADDR_BREATHE, 8'h01);
    clr();
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h01);
    repeat (BREATH) @(posedge sys_clk);
    check(16'(onCnt > BREATH / 4 && onCnt < 3 * BREATH / 4), 16'h1);
    bus_wr(lbs_pkg::ADDR_BREATHE, 8'h02);
    pins(3, 6'h3f);
    repeat (BREATH / 2 - 12) @(posedge sys_clk);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h00);
    clr();
    repeat (40) @(posedge sys_clk);
    check(16'(onCnt > 20), 16'h1);
    repeat (BREATH) @(posedge sys_clk);
    clr();
    repeat (100) @(posedge sys_clk);
    check(onCnt, 16'h0000);
  endtask

  // one and three pulses; the early clear of the drive bit is ignored
  task automatic t_pulse_a(input logic [2:0] code);
    int n;
    n = int'(code) + 1;
    bus_wr(lbs_pkg::ADDR_MODE_LOW, 8'h01);
    bus_wr(lbs_pkg::ADDR_PULSE_A, 8'h01);
    bus_wr(lbs_pkg::ADDR_CONFIG, {5'h00, code});
    clr();
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h01);
    repeat (100) @(posedge sys_clk);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h00);
    repeat (n * BREATH + 600) @(posedge sys_clk);
    check(16'(span > n * BREATH - 160 && span <= n * BREATH), 16'h1);
    pins(1, 6'h3f);
  endtask

  // linked pulse a armed for release: a touch alone must not start it
  task automatic t_release();
    bus_wr(lbs_pkg::ADDR_MODE_LOW, 8'h01);
    bus_wr(lbs_pkg::ADDR_PULSE_A, 8'h81);
    bus_wr(lbs_pkg::ADDR_CONFIG, 8'h00);
    bus_wr(lbs_pkg::ADDR_LINK, 8'h01);
    clr();
    touch(6'h01);
    repeat (BREATH / 2) @(posedge sys_clk);
    check(onCnt, 16'h0000);
    touch(6'h00);
    repeat (BREATH) @(posedge sys_clk);
    check(16'(onCnt > BREATH / 4), 16'h1);
    repeat (200) @(posedge sys_clk);
    pins(1, 6'h3f);
    bus_wr(lbs_pkg::ADDR_LINK, 8'h00);
  endtask

  // pulse b breathes while driven, then two pulses and rest at minimum
  task automatic t_pulse_b();
    bus_wr(lbs_pkg::ADDR_MODE_LOW, 8'h02);
    bus_wr(lbs_pkg::ADDR_PULSE_B, 8'h01);
    bus_wr(lbs_pkg::ADDR_CONFIG, 8'h08);
    clr();
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h01);
    repeat (2 * BREATH) @(posedge sys_clk);
    check(16'(onCnt > BREATH / 2), 16'h1);
    bus_wr(lbs_pkg::ADDR_DRIVE, 8'h00);
    clr();
    repeat (3 * BREATH + 200) @(posedge sys_clk);
    check(16'(onCnt > 3 * BREATH / 4 && onCnt < 2 * BREATH), 16'h1);
    pins(1, 6'h3f);
  endtask

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the roughly ten thousand cycles of the run
  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    busReq = '0;
    touchDetect = 6'h00;
    activeLvl = 6'h00;
    modelClr = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_linked();
    t_unlinked();
    t_breathe();
    t_pulse_a(3'h0);
    t_pulse_a(3'h2);
    t_release();
    t_pulse_b();
    complete_run();
  end
endmodule
